// ---- common/cpu_register_array_pkg.sv ----
// Summary of operation
// (RULE1) Instruction pointer is 16 bits and steps by one after driving a fetch address.
// (RULE2) A taken jump, call or return loads the pointer instead of the increment.
// (RULE3) Stack pointer drops before each pushed byte, rises after each popped byte.
// (RULE4) Stack lives in external memory, last-in first-out, pointer marks its top.
// (RULE5) Two independent 16-bit index bases, either may serve indexed addressing.
// (RULE6) Indexed address is chosen base plus a signed displacement byte.
// (RULE7) Mode-2 table pointer is page register high byte, peripheral byte low.
// (RULE8) The interrupting peripheral supplies an even vector byte.
// (RULE9) Indirect call reads routine low byte at the even slot, high byte next.
// (RULE10) An 8-bit refresh counter steps after every opcode fetch.
// (RULE11) Refresh counter goes out on the low address byte with refresh strobe.
// (RULE12) Refresh fits inside the fetch and adds no cycles.
// (RULE13) Register port can both load and read the refresh counter.
// (RULE14) Six dedicated registers: two of 8 bits, four of 16 bits.
// (RULE15) Sixteen 8-bit working registers: main and alternate sets.
// (RULE16) Only one copy of each pair is visible; the other is kept.
// (RULE17) Accumulator-flags exchange swaps those two with their alternates.
// (RULE18) General exchange swaps the six general registers only.
// (RULE19) Refresh strobe low for the third and fourth fetch states, page on high byte.
// (RULE20) Mode-2 uses one vector strobe to read the low vector byte.
// (RULE21) Two independent selector bits track the active sets.
package cpu_register_array_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int GEN_NUM = 6;
  localparam int GEN_IDX_W = 3;
  localparam int SETS = 2;
  localparam logic [ADDR_W-1:0] WIDE_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] WIDE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_FETCH = 3'h1,
    OP_JUMP = 3'h2,
    OP_PUSH = 3'h3,
    OP_POP = 3'h4,
    OP_INDEX = 3'h5,
    OP_VECTOR = 3'h6
  } op_t;

  typedef enum logic [3:0] {
    SEL_B = 4'h0,
    SEL_C = 4'h1,
    SEL_D = 4'h2,
    SEL_E = 4'h3,
    SEL_H = 4'h4,
    SEL_L = 4'h5,
    SEL_ACC = 4'h6,
    SEL_FLAGS = 4'h7,
    SEL_PAGE = 4'h8,
    SEL_REFRESH = 4'h9,
    SEL_COUNTER = 4'hA,
    SEL_STACK = 4'hB,
    SEL_INDEX1 = 4'hC,
    SEL_INDEX2 = 4'hD
  } reg_sel_t;

  typedef enum logic [11:0] {
    S_IDLE = 12'h001,
    S_FETCH = 12'h002,
    S_RFSH1 = 12'h004,
    S_RFSH2 = 12'h008,
    S_READ = 12'h010,
    S_RDATA = 12'h020,
    S_ACK = 12'h040,
    S_VBYTE = 12'h080,
    S_TLO = 12'h100,
    S_TLOD = 12'h200,
    S_THI = 12'h400,
    S_THID = 12'h800
  } state_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] data;
    logic index_sel;
    logic [DATA_W-1:0] disp;
  } cmd_t;

  typedef struct packed {
    logic wr_en;
    reg_sel_t sel;
    logic [ADDR_W-1:0] wdata;
    logic swap_accumulator_flags_pair;
    logic swap_general_sets;
  } reg_port_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rd_en;
    logic wr_en;
    logic [DATA_W-1:0] wdata;
    logic refresh_strobe_n;
    logic vector_fetch_strobe_n;
    logic opcode_fetch_cycle;
  } bus_t;

  localparam bus_t BUS_IDLE = '{
    addr: WIDE_RST,
    rd_en: 1'b0,
    wr_en: 1'b0,
    wdata: BYTE_RST,
    refresh_strobe_n: 1'b1,
    vector_fetch_strobe_n: 1'b1,
    opcode_fetch_cycle: 1'b0
  };
endpackage

// ---- hdl/cpu_register_array.sv ----
`timescale 1ns/1ns
module cpu_register_array (
  input wire logic CLK,
  input wire logic ARST_N,
  input cpu_register_array_pkg::cmd_t CMD,
  input cpu_register_array_pkg::reg_port_t REGP,
  input wire logic [cpu_register_array_pkg::DATA_W-1:0] MEM_RDATA,
  output cpu_register_array_pkg::bus_t BUS,
  output logic BUSY,
  output logic [cpu_register_array_pkg::DATA_W-1:0] RD_DATA,
  output logic RD_DONE,
  output logic [cpu_register_array_pkg::ADDR_W-1:0] REG_RDATA
);
  import cpu_register_array_pkg::*;

  // ----------------------------------------
  // Sign extension of a displacement byte
  // ----------------------------------------
  function automatic logic [ADDR_W-1:0] sext16(input logic [DATA_W-1:0] b);
    sext16 = {{(ADDR_W-DATA_W){b[DATA_W-1]}}, b};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_t state, next_state;
  logic [ADDR_W-1:0] program_counter, next_program_counter; // RULE14
  logic [ADDR_W-1:0] stack_top_pointer, next_stack_top_pointer; // RULE14
  logic [ADDR_W-1:0] first_index_base, next_first_index_base; // RULE14
  logic [ADDR_W-1:0] second_index_base, next_second_index_base; // RULE14
  logic [DATA_W-1:0] irq_page, next_irq_page; // RULE14
  logic [DATA_W-1:0] refresh_count, next_refresh_count; // RULE14
  logic [DATA_W-1:0] acc_bank [SETS]; // RULE15
  logic [DATA_W-1:0] next_acc_bank [SETS];
  logic [DATA_W-1:0] flag_bank [SETS]; // RULE15
  logic [DATA_W-1:0] next_flag_bank [SETS];
  logic [DATA_W-1:0] gen_bank [SETS][GEN_NUM]; // RULE15
  logic [DATA_W-1:0] next_gen_bank [SETS][GEN_NUM];
  logic af_sel, next_af_sel; // RULE21
  logic gen_sel, next_gen_sel; // RULE21
  logic [DATA_W-1:0] table_lo, next_table_lo;
  logic pop_pend, next_pop_pend;
  bus_t next_bus;
  logic next_busy;
  logic [DATA_W-1:0] next_rd_data;
  logic next_rd_done;
  logic [ADDR_W-1:0] next_reg_rdata;

  // ----------------------------------------
  // Next-value logic
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_program_counter = program_counter;
    next_stack_top_pointer = stack_top_pointer;
    next_first_index_base = first_index_base;
    next_second_index_base = second_index_base;
    next_irq_page = irq_page;
    next_refresh_count = refresh_count;
    next_acc_bank = acc_bank;
    next_flag_bank = flag_bank;
    next_gen_bank = gen_bank;
    next_af_sel = af_sel;
    next_gen_sel = gen_sel;
    next_table_lo = table_lo;
    next_pop_pend = pop_pend;
    next_bus = BUS;
    next_bus.rd_en = 1'b0;
    next_bus.wr_en = 1'b0;
    next_bus.vector_fetch_strobe_n = 1'b1;
    next_rd_data = RD_DATA;
    next_rd_done = 1'b0;
    next_reg_rdata = REG_RDATA;

    // Set exchanges
    if (REGP.swap_accumulator_flags_pair) begin
      next_af_sel = ~af_sel; // RULE17 RULE21
    end
    if (REGP.swap_general_sets) begin
      next_gen_sel = ~gen_sel; // RULE18 RULE21
    end

    // Register port write, into the visible copy only
    if (REGP.wr_en) begin
      unique case (REGP.sel)
        SEL_B, SEL_C, SEL_D, SEL_E, SEL_H, SEL_L: begin
          next_gen_bank[gen_sel][REGP.sel[GEN_IDX_W-1:0]] = REGP.wdata[DATA_W-1:0]; // RULE16
        end
        SEL_ACC: begin
          next_acc_bank[af_sel] = REGP.wdata[DATA_W-1:0]; // RULE16
        end
        SEL_FLAGS: begin
          next_flag_bank[af_sel] = REGP.wdata[DATA_W-1:0]; // RULE16
        end
        SEL_PAGE: begin
          next_irq_page = REGP.wdata[DATA_W-1:0];
        end
        SEL_REFRESH: begin
          next_refresh_count = REGP.wdata[DATA_W-1:0]; // RULE13
        end
        SEL_COUNTER: begin
          next_program_counter = REGP.wdata;
        end
        SEL_STACK: begin
          next_stack_top_pointer = REGP.wdata;
        end
        SEL_INDEX1: begin
          next_first_index_base = REGP.wdata; // RULE5
        end
        SEL_INDEX2: begin
          next_second_index_base = REGP.wdata; // RULE5
        end
        default: begin
        end
      endcase
    end

    // Register port read, of the visible copy
    unique case (REGP.sel)
      SEL_B, SEL_C, SEL_D, SEL_E, SEL_H, SEL_L: begin
        next_reg_rdata = {BYTE_ZERO, gen_bank[gen_sel][REGP.sel[GEN_IDX_W-1:0]]}; // RULE16
      end
      SEL_ACC: begin
        next_reg_rdata = {BYTE_ZERO, acc_bank[af_sel]}; // RULE16
      end
      SEL_FLAGS: begin
        next_reg_rdata = {BYTE_ZERO, flag_bank[af_sel]}; // RULE16
      end
      SEL_PAGE: begin
        next_reg_rdata = {BYTE_ZERO, irq_page};
      end
      SEL_REFRESH: begin
        next_reg_rdata = {BYTE_ZERO, refresh_count}; // RULE13
      end
      SEL_COUNTER: begin
        next_reg_rdata = program_counter;
      end
      SEL_STACK: begin
        next_reg_rdata = stack_top_pointer;
      end
      SEL_INDEX1: begin
        next_reg_rdata = first_index_base;
      end
      SEL_INDEX2: begin
        next_reg_rdata = second_index_base;
      end
      default: begin
        next_reg_rdata = WIDE_RST;
      end
    endcase

    // Sequencer
    unique case (state)
      S_IDLE: begin
        unique case (CMD.op)
          OP_FETCH: begin
            next_bus.addr = program_counter;
            next_bus.rd_en = 1'b1;
            next_bus.opcode_fetch_cycle = 1'b1;
            next_program_counter = program_counter + WIDE_ONE; // RULE1
            next_state = S_FETCH;
          end
          OP_JUMP: begin
            next_program_counter = CMD.data; // RULE2
          end
          OP_PUSH: begin
            next_stack_top_pointer = stack_top_pointer - WIDE_ONE; // RULE3
            next_bus.addr = stack_top_pointer - WIDE_ONE; // RULE4
            next_bus.wr_en = 1'b1;
            next_bus.wdata = CMD.data[DATA_W-1:0];
          end
          OP_POP: begin
            next_bus.addr = stack_top_pointer; // RULE4
            next_bus.rd_en = 1'b1;
            next_pop_pend = 1'b1;
            next_state = S_READ;
          end
          OP_INDEX: begin
            if (CMD.index_sel) begin
              next_bus.addr = second_index_base + sext16(CMD.disp); // RULE5 RULE6
            end else begin
              next_bus.addr = first_index_base + sext16(CMD.disp); // RULE5 RULE6
            end
            next_bus.rd_en = 1'b1;
            next_state = S_READ;
          end
          OP_VECTOR: begin
            next_bus.vector_fetch_strobe_n = 1'b0; // RULE20
            next_state = S_ACK;
          end
          OP_NONE: begin
          end
          default: begin
          end
        endcase
      end
      S_FETCH: begin
        next_bus.addr = {irq_page, refresh_count}; // RULE11 RULE19
        next_bus.refresh_strobe_n = 1'b0; // RULE19
        next_state = S_RFSH1;
      end
      S_RFSH1: begin
        next_rd_data = MEM_RDATA;
        next_rd_done = 1'b1;
        next_state = S_RFSH2;
      end
      S_RFSH2: begin
        next_bus.refresh_strobe_n = 1'b1; // RULE12
        next_bus.opcode_fetch_cycle = 1'b0;
        next_refresh_count = refresh_count + BYTE_ONE; // RULE10
        next_state = S_IDLE;
      end
      S_READ: begin
        next_state = S_RDATA;
      end
      S_RDATA: begin
        next_rd_data = MEM_RDATA;
        next_rd_done = 1'b1;
        if (pop_pend) begin
          next_stack_top_pointer = stack_top_pointer + WIDE_ONE; // RULE3
        end
        next_pop_pend = 1'b0;
        next_state = S_IDLE;
      end
      S_ACK: begin
        next_state = S_VBYTE;
      end
      S_VBYTE: begin
        next_bus.addr = {irq_page, MEM_RDATA}; // RULE7 RULE8
        next_bus.rd_en = 1'b1;
        next_state = S_TLO;
      end
      S_TLO: begin
        next_state = S_TLOD;
      end
      S_TLOD: begin
        next_table_lo = MEM_RDATA; // RULE9
        next_bus.addr = BUS.addr + WIDE_ONE; // RULE9
        next_bus.rd_en = 1'b1;
        next_state = S_THI;
      end
      S_THI: begin
        next_state = S_THID;
      end
      S_THID: begin
        next_program_counter = {MEM_RDATA, table_lo}; // RULE9
        next_state = S_IDLE;
      end
    endcase
    next_busy = (next_state != S_IDLE);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= S_IDLE;
      program_counter <= WIDE_RST;
      stack_top_pointer <= WIDE_RST;
      first_index_base <= WIDE_RST;
      second_index_base <= WIDE_RST;
      irq_page <= BYTE_RST;
      refresh_count <= BYTE_RST;
      for (int s = 0; s < SETS; s++) begin
        acc_bank[s] <= BYTE_RST;
        flag_bank[s] <= BYTE_RST;
        for (int g = 0; g < GEN_NUM; g++) begin
          gen_bank[s][g] <= BYTE_RST;
        end
      end
      af_sel <= 1'b0;
      gen_sel <= 1'b0;
      table_lo <= BYTE_RST;
      pop_pend <= 1'b0;
      BUS <= BUS_IDLE;
      BUSY <= 1'b0;
      RD_DATA <= BYTE_RST;
      RD_DONE <= 1'b0;
      REG_RDATA <= WIDE_RST;
    end else begin
      state <= next_state;
      program_counter <= next_program_counter;
      stack_top_pointer <= next_stack_top_pointer;
      first_index_base <= next_first_index_base;
      second_index_base <= next_second_index_base;
      irq_page <= next_irq_page;
      refresh_count <= next_refresh_count;
      acc_bank <= next_acc_bank;
      flag_bank <= next_flag_bank;
      gen_bank <= next_gen_bank;
      af_sel <= next_af_sel;
      gen_sel <= next_gen_sel;
      table_lo <= next_table_lo;
      pop_pend <= next_pop_pend;
      BUS <= next_bus;
      BUSY <= next_busy;
      RD_DATA <= next_rd_data;
      RD_DONE <= next_rd_done;
      REG_RDATA <= next_reg_rdata;
    end
  end
endmodule

// ---- sim/cpu_register_array_sva.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module cpu_register_array_sva
  import cpu_register_array_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input cpu_register_array_pkg::cmd_t CMD,
  input cpu_register_array_pkg::bus_t BUS,
  input wire logic BUSY,
  input wire logic RD_DONE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic go_f;
  logic go_r;
  logic go_p;
  logic go_v;
  assign go_f = !BUSY && CMD.op == OP_FETCH;
  assign go_r = !BUSY && (CMD.op == OP_POP || CMD.op == OP_INDEX);
  assign go_p = !BUSY && CMD.op == OP_PUSH;
  assign go_v = !BUSY && CMD.op == OP_VECTOR;
  sequence s_refresh_strobe_n;
    !BUS.refresh_strobe_n [*2] ##1 BUS.refresh_strobe_n;
  endsequence
  sequence s_vec;
    !BUS.vector_fetch_strobe_n ##1 BUS.vector_fetch_strobe_n;
  endsequence
  AST_FETCH_OUT: assert property (go_f |=> BUS.rd_en && BUS.opcode_fetch_cycle)
    else $error("fetch strobe missing");
  AST_REFRESH_STROBE_N_WIN: assert property (go_f |=> ##1 s_refresh_strobe_n)
    else $error("refresh window wrong");
  AST_REFRESH_STROBE_N_IN_FETCH: assert property ($fell(BUS.refresh_strobe_n) |-> BUS.opcode_fetch_cycle)
    else $error("refresh outside fetch");
  AST_FETCH_LEN: assert property (go_f |=> BUSY [*3] ##1 !BUSY)
    else $error("fetch length wrong");
  AST_FETCH_DONE: assert property (go_f |-> ##3 RD_DONE)
    else $error("fetch done late");
  AST_READ_SEQ: assert property (go_r |=> BUS.rd_en ##1 !BUS.rd_en ##1 RD_DONE && !BUSY)
    else $error("read sequence wrong");
  AST_PUSH_OUT: assert property (go_p |=> BUS.wr_en && BUS.wdata == $past(CMD.data[7:0]))
    else $error("push write wrong");
  AST_VEC_SEQ: assert property (go_v |=> s_vec ##1 (BUS.rd_en && !BUS.addr[0]) ##2
    (BUS.rd_en && BUS.addr[0])) else $error("vector sequence wrong");
  AST_VEC_ONE: assert property ($fell(BUS.vector_fetch_strobe_n) |=> BUS.vector_fetch_strobe_n)
    else $error("vector strobe too long");
endmodule
bind cpu_register_array cpu_register_array_sva chk_u (.CLK(CLK), .ARST_N(ARST_N), .CMD(CMD),
  .BUS(BUS), .BUSY(BUSY), .RD_DONE(RD_DONE));

// ---- sim/mem_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Memory and interrupting peripheral
// ----------------------------------------
module mem_model
  import cpu_register_array_pkg::*;
(
  input wire logic CLK,
  input cpu_register_array_pkg::bus_t BUS,
  input wire logic [7:0] VEC,
  output logic [7:0] MEM_RDATA
);
  logic [7:0] mem [65536];
  initial begin
    MEM_RDATA = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
    end
  end
  always @(posedge CLK) begin
    if (BUS.wr_en) begin
      mem[BUS.addr] <= BUS.wdata;
    end
    if (BUS.rd_en) begin
      MEM_RDATA <= mem[BUS.addr];
    end else if (!BUS.vector_fetch_strobe_n) begin
      MEM_RDATA <= {VEC[7:1], 1'b0};
    end else begin
      MEM_RDATA <= ~MEM_RDATA;
    end
  end
endmodule

// ---- sim/test_cpu_register_array.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Testbench
// ----------------------------------------
module test_cpu_register_array;
  import cpu_register_array_pkg::*;
  logic CLK;
  logic ARST_N;
  cmd_t CMD;
  reg_port_t REGP;
  bus_t BUS;
  bus_t b1;
  bus_t b2;
  logic BUSY;
  logic RD_DONE;
  logic [7:0] MEM_RDATA;
  logic [7:0] RD_DATA;
  logic [7:0] VEC;
  logic [15:0] REG_RDATA;
  logic [15:0] v;
  int fails;
  int compares;
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  cpu_register_array dut_u (.CLK(CLK), .ARST_N(ARST_N), .CMD(CMD), .REGP(REGP),
    .MEM_RDATA(MEM_RDATA), .BUS(BUS), .BUSY(BUSY), .RD_DATA(RD_DATA), .RD_DONE(RD_DONE),
    .REG_RDATA(REG_RDATA));
  mem_model mem_u (.CLK(CLK), .BUS(BUS), .VEC(VEC), .MEM_RDATA(MEM_RDATA));
  function automatic logic [7:0] pat(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(reg_sel_t s, logic [15:0] d);
    @(posedge CLK);
    REGP.wr_en <= 1'b1;
    REGP.sel <= s;
    REGP.wdata <= d;
    @(posedge CLK);
    REGP.wr_en <= 1'b0;
  endtask
  task automatic rd(reg_sel_t s);
    @(posedge CLK);
    REGP.sel <= s;
    @(posedge CLK);
    #1 v = REG_RDATA;
  endtask
  task automatic sw(logic a, logic g);
    @(posedge CLK);
    REGP.swap_accumulator_flags_pair <= a;
    REGP.swap_general_sets <= g;
    @(posedge CLK);
    REGP.swap_accumulator_flags_pair <= 1'b0;
    REGP.swap_general_sets <= 1'b0;
  endtask
  task automatic op(op_t o, logic [15:0] d, logic s, logic [7:0] dp);
    int n;
    @(posedge CLK);
    CMD <= '{op: o, data: d, index_sel: s, disp: dp};
    @(posedge CLK);
    CMD.op <= OP_NONE;
    #1 b1 = BUS;
    @(posedge CLK);
    #1 b2 = BUS;
    n = 0;
    while (BUSY !== 1'b0 && n < 20) begin
      @(posedge CLK);
      #1 n++;
    end
    chk({15'h0000, BUSY}, 16'h0000);
  endtask
  task automatic t_fetch();
    wr(SEL_COUNTER, 16'h1234);
    wr(SEL_PAGE, 16'h003C);
    wr(SEL_REFRESH, 16'h00FF);
    op(OP_FETCH, 16'h0000, 1'b0, 8'h00);
    chk(b1.addr, 16'h1234);
    chk(b2.addr, 16'h3CFF);
    chk({8'h00, RD_DATA}, {8'h00, pat(16'h1234)});
    rd(SEL_COUNTER);
    chk(v, 16'h1235);
    rd(SEL_PAGE);
    chk(v, 16'h003C);
    rd(SEL_REFRESH);
    chk(v, 16'h0000);
    op(OP_JUMP, 16'hABCD, 1'b0, 8'h00);
    rd(SEL_COUNTER);
    chk(v, 16'hABCD);
    $display("test fetch and jump done");
  endtask
  task automatic t_stack();
    wr(SEL_STACK, 16'h0100);
    op(OP_PUSH, 16'h0011, 1'b0, 8'h00);
    op(OP_PUSH, 16'h0022, 1'b0, 8'h00);
    chk(b1.addr, 16'h00FE);
    op(OP_POP, 16'h0000, 1'b0, 8'h00);
    chk({8'h00, RD_DATA}, 16'h0022);
    op(OP_POP, 16'h0000, 1'b0, 8'h00);
    chk({8'h00, RD_DATA}, 16'h0011);
    rd(SEL_STACK);
    chk(v, 16'h0100);
    $display("test stack done");
  endtask
  task automatic t_index();
    wr(SEL_INDEX1, 16'h1000);
    wr(SEL_INDEX2, 16'h2000);
    op(OP_INDEX, 16'h0000, 1'b0, 8'hFE);
    chk(b1.addr, 16'h0FFE);
    chk({8'h00, RD_DATA}, {8'h00, pat(16'h0FFE)});
    op(OP_INDEX, 16'h0000, 1'b1, 8'h7F);
    chk(b1.addr, 16'h207F);
    rd(SEL_INDEX2);
    chk(v, 16'h2000);
    VEC <= 8'h11;
    op(OP_VECTOR, 16'h0000, 1'b0, 8'h00);
    rd(SEL_COUNTER);
    chk(v, {pat(16'h3C11), pat(16'h3C10)});
    $display("test index and vector done");
  endtask
  task automatic t_swap();
    wr(SEL_ACC, 16'h00AA);
    wr(SEL_FLAGS, 16'h00C5);
    wr(SEL_B, 16'h00BB);
    wr(SEL_L, 16'h0077);
    sw(1'b1, 1'b0);
    rd(SEL_ACC);
    chk(v, 16'h0000);
    rd(SEL_FLAGS);
    chk(v, 16'h0000);
    rd(SEL_B);
    chk(v, 16'h00BB);
    sw(1'b1, 1'b0);
    rd(SEL_ACC);
    chk(v, 16'h00AA);
    rd(SEL_FLAGS);
    chk(v, 16'h00C5);
    sw(1'b0, 1'b1);
    rd(SEL_B);
    chk(v, 16'h0000);
    rd(SEL_L);
    chk(v, 16'h0000);
    rd(SEL_ACC);
    chk(v, 16'h00AA);
    sw(1'b0, 1'b1);
    rd(SEL_B);
    chk(v, 16'h00BB);
    rd(SEL_L);
    chk(v, 16'h0077);
    $display("test swap done");
  endtask
  task automatic t_reset();
    @(posedge CLK);
    ARST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b1;
    rd(SEL_COUNTER);
    chk(v, 16'h0000);
    rd(SEL_ACC);
    chk(v, 16'h0000);
    $display("test reset done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end
  initial begin
    ARST_N = 1'b0;
    CMD = '{op: OP_NONE, data: 16'h0000, index_sel: 1'b0, disp: 8'h00};
    REGP = '{wr_en: 1'b0, sel: SEL_B, wdata: 16'h0000, swap_accumulator_flags_pair: 1'b0,
      swap_general_sets: 1'b0};
    VEC = 8'h00;
    fails = 0;
    compares = 0;
    repeat (16) @(posedge CLK);
    ARST_N <= 1'b1;
    t_fetch();
    t_stack();
    t_index();
    t_swap();
    t_reset();
    tally_and_finish();
  end
endmodule
